/* src/lbd_pkg.sv */
/*
  package for the lcd blink and display select block: constants, types and the contract list.
  assumes a single 25 MHz clock domain and a frame-boundary strobe from the waveform logic.
*/
//
// Contract
// - blink clock is lcd clock over (mux plus one) times two to (prescale plus two)
// - blink divider is held cleared while blink mode is 00
// - modes 01 or 10 blank at next frame, then show, each half period
// - up to 4-mux, blink memory may serve as second display memory
// - mode 00: select bit chooses memory, change applied at frame boundary
// - mode 11 alternates memories by divider, select reads back displayed memory
// - mode 11 shows segment memory first half, blink memory second half
// - supply source when select 1 and ref 0; pump when select 0 and pump on
// - pump pauses when enable cleared with level nonzero or auto pause bits
// - mux 0000 to 0111 give value plus one commons; static two levels else four
// - up to 4-mux: 01 individual blink, 10 all blink, 00 off
// - 5-mux and above: only 10 blinks all, others leave blinking off
package lbd_pkg;
  localparam int MUX_W        = 4;
  localparam int PRE_W        = 3;
  localparam int DIV_W        = 16;
  localparam int PRE_OFFSET   = 2;
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_INDIV = 2'h1;
  localparam logic [1:0] MODE_ALL   = 2'h2;
  localparam logic [1:0] MODE_ALT   = 2'h3;
  localparam logic [MUX_W-1:0] MUX_4 = 4'h3;
  localparam logic [MUX_W-1:0] MUX_8 = 4'h7;
  localparam logic [3:0] LEVELS_STATIC = 4'h2;
  localparam logic [3:0] LEVELS_BIAS   = 4'h4;

  typedef enum logic [1:0] {LBD_SRC_NONE, LBD_SRC_SUPPLY, LBD_SRC_PUMP} lbd_src_e;

  typedef struct packed {
    logic [1:0]       blink_mode_select;
    logic [PRE_W-1:0] blink_prescale;
    logic [MUX_W-1:0] mux_select;
    logic             display_memory_select;
  } lbd_cfg_s;

  typedef struct packed {
    logic             supply_source_select;
    logic             reference_enable;
    logic             charge_pump_enable;
    logic [3:0]       lcd_voltage_level;
    logic             auto_pause;
  } lbd_volt_s;
endpackage

/* src/lbd_blink_div.sv */
/*
  blink divider: counts lcd clock ticks and toggles the blink clock each half period.
  assumes lcd_tick_in is a one-cycle pulse per lcd clock period.
*/
`timescale 1ns/1ps
module lbd_blink_div
#(
  parameter int DIV_W = lbd_pkg::DIV_W
)
(
  input  wire logic             clock_in,     // system clock
  input  wire logic             rstn_in,      // async reset, active low
  input  wire logic             clear_in,     // hold divider cleared
  input  wire logic             lcd_tick_in,  // lcd clock tick
  input  wire logic [DIV_W-1:0] half_in,      // half period in lcd ticks
  output logic                  blink_clock_out, // blink clock level
  output logic                  edge_out      // pulse on each blink clock toggle
);
  logic [DIV_W-1:0] count;
  wire              wrap = lcd_tick_in && (count >= half_in - DIV_W'(1));

  // counter with synchronous hold; hold keeps phase at zero so blinking starts fresh
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count           <= '0;
      blink_clock_out <= 1'b0;
      edge_out        <= 1'b0;
    end
    else if (clear_in)
    begin
      count           <= '0;
      blink_clock_out <= 1'b0;
      edge_out        <= 1'b0;
    end
    else
    begin
      edge_out <= wrap;
      if (wrap)
      begin
        count           <= '0;
        blink_clock_out <= ~blink_clock_out;
      end
      else if (lcd_tick_in)
        count <= count + DIV_W'(1);
    end
  end
endmodule

/* src/lbd_top.sv */
/*
  lcd blink and display select control: blink divider, blink phase, memory select,
  mux decode and voltage source select.
  assumes lcd_tick_in and frame_in are one-cycle pulses synchronous to clock_in.
*/
`timescale 1ns/1ps
module lbd_top
(
  input  wire logic              clock_in,          // 25 MHz system clock
  input  wire logic              rstn_in,           // async reset, active low
  input  wire logic              lcd_tick_in,       // lcd clock tick pulse
  input  wire logic              frame_in,          // frame boundary pulse
  input  wire lbd_pkg::lbd_cfg_s cfg_in,            // blink and display config
  input  wire lbd_pkg::lbd_volt_s volt_in,          // voltage config
  input  wire logic              pause_window_in,   // auto pause period active
  output logic                   blank_sel_out,     // blank enabled segments
  output logic                   blank_all_out,     // blank all segments
  output logic                   show_blink_mem_out, // display memory is blink memory
  output logic                   disp_status_out,   // readback of displayed memory
  output logic                   blink_clock_out,   // blink clock level
  output logic [3:0]             com_lines_out,     // number of common lines
  output logic [3:0]             volt_levels_out,   // number of voltage levels
  output logic                   bias_third_out,    // one-third bias in use
  output logic [1:0]             vsrc_out,          // voltage source, lbd_src_e
  output logic                   pump_run_out       // charge pump running
);
  localparam int DIV_W = lbd_pkg::DIV_W;

  // mux classification used in several places
  function automatic logic low_mux(input logic [lbd_pkg::MUX_W-1:0] m);
    return m <= lbd_pkg::MUX_4;
  endfunction

  wire [1:0] mode     = cfg_in.blink_mode_select;
  wire       is_low   = low_mux(cfg_in.mux_select);
  // in 5-mux and above only all-segment blinking is kept
  wire       run_indv = is_low && (mode == lbd_pkg::MODE_INDIV);
  wire       run_all  = (mode == lbd_pkg::MODE_ALL);
  wire       run_alt  = is_low && (mode == lbd_pkg::MODE_ALT);
  wire       blinking = run_indv || run_all || run_alt;
  wire       dual_ok  = is_low && !run_indv && !run_all;

  // half period = (mux+1) * 2^(pre+2) / 2 lcd ticks
  wire [DIV_W-1:0] mux_p1 = DIV_W'(cfg_in.mux_select) + DIV_W'(1);
  wire [DIV_W-1:0] half   = DIV_W'(mux_p1 << (cfg_in.blink_prescale
                                              + lbd_pkg::PRE_OFFSET - 1));

  logic bclk;
  logic bedge;
  lbd_blink_div #(.DIV_W(DIV_W)) u_div
  (
    .clock_in        (clock_in),
    .rstn_in         (rstn_in),
    .clear_in        (!blinking),
    .lcd_tick_in     (lcd_tick_in),
    .half_in         (half),
    .blink_clock_out (bclk),
    .edge_out        (bedge)
  );

  // pending phase follows divider; first half after entry is blank / segment memory
  logic want_phase;
  wire  next_want = !blinking ? 1'b0 : (bedge ? ~want_phase : want_phase);

  // displayed memory target
  wire next_mem_target = run_alt ? want_phase
                       : (dual_ok && mode == lbd_pkg::MODE_OFF)
                         ? cfg_in.display_memory_select : 1'b0;

  // phase follows the divider every cycle; memory and blank levels only move on the frame strobe so nothing changes mid-frame
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      want_phase         <= 1'b0;
      show_blink_mem_out <= 1'b0;
      blank_sel_out      <= 1'b0;
      blank_all_out      <= 1'b0;
    end
    else
    begin
      want_phase <= next_want;
      if (frame_in)
      begin
        show_blink_mem_out <= next_mem_target;
        blank_sel_out      <= run_indv && ~next_want;
        blank_all_out      <= run_all && ~next_want;
      end
    end
  end

  // status and static decodes, registered for clean outputs
  wire [3:0] next_com   = (cfg_in.mux_select <= lbd_pkg::MUX_8)
                          ? 4'(cfg_in.mux_select) + 4'h1 : 4'h0;
  wire       is_static  = (cfg_in.mux_select == '0);
  wire [3:0] next_lvl   = is_static ? lbd_pkg::LEVELS_STATIC : lbd_pkg::LEVELS_BIAS;
  wire       sel_supply = volt_in.supply_source_select && !volt_in.reference_enable;
  wire       sel_pump   = !volt_in.supply_source_select && volt_in.charge_pump_enable;
  wire [1:0] next_src   = sel_supply ? 2'(lbd_pkg::LBD_SRC_SUPPLY)
                        : sel_pump   ? 2'(lbd_pkg::LBD_SRC_PUMP)
                        : 2'(lbd_pkg::LBD_SRC_NONE);
  // pausing keeps cap voltage in use; auto pause only gates an enabled pump
  wire       next_pump  = sel_pump && !(volt_in.auto_pause && pause_window_in);

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      disp_status_out <= 1'b0;
      blink_clock_out <= 1'b0;
      com_lines_out   <= 4'h0;
      volt_levels_out <= 4'h0;
      bias_third_out  <= 1'b0;
      vsrc_out        <= 2'h0;
      pump_run_out    <= 1'b0;
    end
    else
    begin
      disp_status_out <= show_blink_mem_out;
      blink_clock_out <= bclk;
      com_lines_out   <= next_com;
      volt_levels_out <= next_lvl;
      bias_third_out  <= !is_static;
      vsrc_out        <= next_src;
      pump_run_out    <= next_pump;
    end
  end

  // assertions
  property p_div_hold;
    @(posedge clock_in) disable iff (!rstn_in)
      (mode == lbd_pkg::MODE_OFF) |=> (bclk == 1'b0);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider ran in mode 00");

  property p_frame_only;
    @(posedge clock_in) disable iff (!rstn_in)
      !frame_in |=> $stable(show_blink_mem_out) && $stable(blank_all_out);
  endproperty
  a_frame_only: assert property (p_frame_only)
    else $error("display changed mid-frame");

  property p_manual_sel;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && mode == lbd_pkg::MODE_OFF && is_low)
        |=> (show_blink_mem_out == $past(cfg_in.display_memory_select));
  endproperty
  a_manual_sel: assert property (p_manual_sel) else $error("manual select wrong");

  property p_high_mux_no_indiv;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && !is_low) |=> !blank_sel_out && !show_blink_mem_out;
  endproperty
  a_high_mux_no_indiv: assert property (p_high_mux_no_indiv)
    else $error("bad blink >4mux");

  property p_first_blank;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && run_all && !want_phase && !bedge) |=> blank_all_out;
  endproperty
  a_first_blank: assert property (p_first_blank) else $error("no blank after entry");

  property p_status;
    @(posedge clock_in) disable iff (!rstn_in)
      1'b1 |=> (disp_status_out == $past(show_blink_mem_out));
  endproperty
  a_status: assert property (p_status) else $error("status mismatch");

  property p_alt_first;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && run_alt && !want_phase && !bedge) |=> !show_blink_mem_out;
  endproperty
  a_alt_first: assert property (p_alt_first) else $error("alt phase wrong");

  property p_com;
    @(posedge clock_in) disable iff (!rstn_in)
      (cfg_in.mux_select == 4'h3) |=> (com_lines_out == 4'h4);
  endproperty
  a_com: assert property (p_com) else $error("com decode wrong");

  property p_src;
    @(posedge clock_in) disable iff (!rstn_in)
      (volt_in.supply_source_select && !volt_in.reference_enable)
        |=> (vsrc_out == 2'(lbd_pkg::LBD_SRC_SUPPLY));
  endproperty
  a_src: assert property (p_src) else $error("supply select wrong");

  property p_pause;
    @(posedge clock_in) disable iff (!rstn_in)
      !volt_in.charge_pump_enable |=> !pump_run_out;
  endproperty
  a_pause: assert property (p_pause) else $error("pump not paused");

  // blank levels follow the phase only at a frame; a missed edge would slip half a period
  property p_frame_only_sel;
    @(posedge clock_in) disable iff (!rstn_in)
      !frame_in |=> $stable(blank_sel_out);
  endproperty
  a_frame_only_sel: assert property (p_frame_only_sel)
    else $error("select blank changed mid-frame");

  property p_indiv_first;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && run_indv && !want_phase && !bedge) |=> blank_sel_out;
  endproperty
  a_indiv_first: assert property (p_indiv_first)
    else $error("selected segments not blanked");

  property p_indiv_show;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && run_indv && want_phase && !bedge) |=> !blank_sel_out;
  endproperty
  a_indiv_show: assert property (p_indiv_show)
    else $error("selected segments not shown");

  property p_all_show;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && run_all && want_phase && !bedge) |=> !blank_all_out;
  endproperty
  a_all_show: assert property (p_all_show)
    else $error("all segments not shown");

  property p_no_blink_off;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && mode == lbd_pkg::MODE_OFF) |=> !blank_sel_out && !blank_all_out;
  endproperty
  a_no_blink_off: assert property (p_no_blink_off)
    else $error("blank while blinking off");

  // high mux keeps only all-segment blinking; blink memory never shows while segments blink
  property p_high_all;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && !is_low && mode == lbd_pkg::MODE_ALL && !want_phase && !bedge)
        |=> blank_all_out;
  endproperty
  a_high_all: assert property (p_high_all)
    else $error("all blink lost above 4-mux");

  property p_high_alt_off;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && !is_low && mode == lbd_pkg::MODE_ALT)
        |=> !show_blink_mem_out && !blank_all_out;
  endproperty
  a_high_alt_off: assert property (p_high_alt_off)
    else $error("alternation above 4-mux");

  property p_blink_hides_bm;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && (run_indv || run_all)) |=> !show_blink_mem_out;
  endproperty
  a_blink_hides_bm: assert property (p_blink_hides_bm)
    else $error("blink memory shown while blinking");

  property p_alt_second;
    @(posedge clock_in) disable iff (!rstn_in)
      (frame_in && run_alt && want_phase && !bedge) |=> show_blink_mem_out;
  endproperty
  a_alt_second: assert property (p_alt_second)
    else $error("second half not blink memory");

  // divider: toggles only after a tick, holds otherwise, phase cleared while idle
  property p_phase_clear;
    @(posedge clock_in) disable iff (!rstn_in)
      !blinking |=> !want_phase;
  endproperty
  a_phase_clear: assert property (p_phase_clear)
    else $error("phase kept while idle");

  property p_tick_edge;
    @(posedge clock_in) disable iff (!rstn_in)
      bedge |-> $past(lcd_tick_in);
  endproperty
  a_tick_edge: assert property (p_tick_edge)
    else $error("blink edge without lcd tick");

  property p_bclk_toggle;
    @(posedge clock_in) disable iff (!rstn_in)
      bedge |-> (bclk != $past(bclk));
  endproperty
  a_bclk_toggle: assert property (p_bclk_toggle)
    else $error("blink clock did not toggle");

  property p_bclk_hold;
    @(posedge clock_in) disable iff (!rstn_in)
      (!bedge && $past(blinking)) |-> $stable(bclk);
  endproperty
  a_bclk_hold: assert property (p_bclk_hold)
    else $error("blink clock moved without edge");

  // static decodes and voltage source
  property p_static_lvl;
    @(posedge clock_in) disable iff (!rstn_in)
      (cfg_in.mux_select == '0) |=> (volt_levels_out == lbd_pkg::LEVELS_STATIC) && !bias_third_out;
  endproperty
  a_static_lvl: assert property (p_static_lvl)
    else $error("static levels wrong");

  property p_bias_lvl;
    @(posedge clock_in) disable iff (!rstn_in)
      (cfg_in.mux_select != '0) |=> (volt_levels_out == lbd_pkg::LEVELS_BIAS) && bias_third_out;
  endproperty
  a_bias_lvl: assert property (p_bias_lvl)
    else $error("bias levels wrong");

  property p_pump_src;
    @(posedge clock_in) disable iff (!rstn_in)
      (!volt_in.supply_source_select && volt_in.charge_pump_enable)
        |=> (vsrc_out == 2'(lbd_pkg::LBD_SRC_PUMP));
  endproperty
  a_pump_src: assert property (p_pump_src)
    else $error("pump select wrong");

  property p_auto_pause;
    @(posedge clock_in) disable iff (!rstn_in)
      (volt_in.auto_pause && pause_window_in) |=> !pump_run_out;
  endproperty
  a_auto_pause: assert property (p_auto_pause)
    else $error("pump ran in pause window");

  c_blink_all: cover property (@(posedge clock_in) disable iff (!rstn_in)
                               run_all && blank_all_out ##[1:1000] !blank_all_out);
  c_alt: cover property (@(posedge clock_in) disable iff (!rstn_in)
                         run_alt && show_blink_mem_out);
  c_indiv: cover property (@(posedge clock_in) disable iff (!rstn_in) blank_sel_out);
  c_manual: cover property (@(posedge clock_in) disable iff (!rstn_in)
                            mode == lbd_pkg::MODE_OFF && show_blink_mem_out);
  c_pause: cover property (@(posedge clock_in) disable iff (!rstn_in)
                           volt_in.charge_pump_enable && !pump_run_out);
endmodule

/* tb/lbd_glass.sv */
/*
  lcd glass model: holds one byte of each memory and shows its lit segments.
  assumes the blank and memory select levels of the block settle on clock_in.
*/
`timescale 1ns/1ps
module lbd_glass
(
  input  wire logic       clock_in,     // system clock
  input  wire logic       blank_sel_in, // blank blink-enabled segments
  input  wire logic       blank_all_in, // blank all segments
  input  wire logic       show_bm_in,   // blink memory on display
  output logic [7:0]      lit_out       // visible segments of byte 2
);
  logic [15:0] pad_fn;
  logic [15:0] com_sel;
  logic [7:0]  seg_mem;
  logic [7:0]  bm_mem;
  // software setup: all pads lcd pins, pads 0 to 3 commons
  initial
  begin
    pad_fn  = 16'hffff;
    com_sel = 16'h000f;
    seg_mem = 8'h02;
    bm_mem  = 8'h02; // same com byte in both memories
  end
  // glass shows nothing while blanked, otherwise the chosen memory
  always_ff @(posedge clock_in)
    lit_out <= (blank_all_in || blank_sel_in) ? 8'h00 : (show_bm_in ? bm_mem : seg_mem);
endmodule

/* tb/tb_lcd_blink_and_display_select.sv */
/*
  self-checking bench for the lcd blink and display select block.
  assumes lbd_top and the lbd_glass model; one 25 MHz clock.
*/
`timescale 1ns/1ps
module tb_lcd_blink_and_display_select;
  logic               clock_in = 1'b0;
  logic               rstn_in  = 1'b0;
  logic               tick     = 1'b0;
  logic               frame    = 1'b0;
  logic               pwin     = 1'b0;
  lbd_pkg::lbd_cfg_s  cfg      = '0;
  lbd_pkg::lbd_volt_s volt     = '0;
  logic               b_sel, b_all, show, stat, bclk, bias, prun, ds;
  logic               e_sel, e_all, e_show, e_clk;
  logic [3:0]         coms, lvls;
  logic [1:0]         vsrc;
  logic [7:0]         lit, v;
  logic [31:0]        seed = 32'h0001_1443;
  int                 miscompares = 0;
  int                 cmp_count = 0;
  int                 cnt, half, mode, mux;

  // 40 ns period
  always #20 clock_in = ~clock_in;

  lbd_top i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .lcd_tick_in(tick),
    .frame_in(frame), .cfg_in(cfg), .volt_in(volt), .pause_window_in(pwin),
    .blank_sel_out(b_sel), .blank_all_out(b_all), .show_blink_mem_out(show),
    .disp_status_out(stat), .blink_clock_out(bclk), .com_lines_out(coms),
    .volt_levels_out(lvls), .bias_third_out(bias), .vsrc_out(vsrc), .pump_run_out(prun));

  lbd_glass i_glass (.clock_in(clock_in), .blank_sel_in(b_sel), .blank_all_in(b_all),
    .show_bm_in(show), .lit_out(lit));

  // xorshift source, fixed seed so runs repeat
  function automatic void step_rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_disp();
    @(negedge clock_in);
    chk_bit(b_sel, e_sel);
    chk_bit(b_all, e_all);
    chk_bit(show, e_show);
    chk_bit(stat, e_show);
    chk_bit(bclk, e_clk);
    chk_val(lit, (e_sel || e_all) ? 8'h00 : 8'h02);
  endtask

  // n lcd ticks, then a frame; blank and memory outputs must hold until the frame lands, blink clock follows the ticks
  task automatic frame_step(input int n);
    step_rnd();
    @(posedge clock_in);
    cfg.display_memory_select <= seed[0];
    ds = seed[0];
    repeat (n)
    begin
      @(posedge clock_in);
      tick <= 1'b1;
      @(posedge clock_in);
      tick <= 1'b0;
    end
    cnt += (mode != 0) ? n : 0; // divider idle in mode off
    // blink clock level: one toggle per half period of ticks while a blink mode runs
    e_clk = (mode == 2 || (mux <= 3 && mode % 2 == 1)) && (cnt / half) % 2 == 1;
    cyc(3);
    chk_disp();
    @(posedge clock_in);
    frame <= 1'b1;
    @(posedge clock_in);
    frame <= 1'b0;
    e_sel = mode == 1 && mux <= 3 && (cnt / half) % 2 == 0;
    e_all = mode == 2 && (cnt / half) % 2 == 0;
    e_show = mux <= 3 && ((mode == 3 && (cnt / half) % 2 == 1) || (mode == 0 && ds));
    cyc(1);
    chk_disp();
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // every blink mode against static, 4-mux, 5-mux and 8-mux, then decodes
  initial
  begin
    e_sel = 1'b0;
    e_all = 1'b0;
    e_show = 1'b0;
    e_clk = 1'b0;
    cyc(3);
    rstn_in <= 1'b1;
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 4; k++)
      begin
        @(posedge clock_in);
        cfg.blink_mode_select <= lbd_pkg::MODE_OFF;
        mode = 0;
        cnt = 0;
        step_rnd();
        mux = 2 * k + k % 2;
        @(posedge clock_in);
        cfg.mux_select <= 4'(mux);
        cfg.blink_prescale <= 3'(seed % 3); // only while blinking is off
        half = (mux + 1) << (seed % 3 + 1);
        frame_step(3);
        @(posedge clock_in);
        cfg.blink_mode_select <= 2'(m);
        mode = m;
        repeat (5)
        begin
          step_rnd();
          frame_step(1 + int'(seed % half)); // blink slower than frame
        end
      end
    repeat (16)
    begin
      step_rnd();
      v = seed[11:4];
      v[5] = v[5] & ~v[7];
      @(posedge clock_in);
      cfg.mux_select <= seed[3:0];
      volt <= v;
      pwin <= seed[12];
      cyc(2);
      @(negedge clock_in);
      mux = int'(seed[3:0]);
      chk_val(coms, mux <= 7 ? 4'(mux + 1) : 4'h0);
      chk_val(lvls, mux == 0 ? 4'h2 : 4'h4);
      chk_bit(bias, mux != 0);
      chk_val({2'h0, vsrc}, (v[7] && !v[6]) ? 4'h1 : (!v[7] && v[5]) ? 4'h2 : 4'h0);
      chk_bit(prun, !v[7] && v[5] && !(v[0] && seed[12]));
    end
    end_sim();
  end

  // cut a hang well past the few thousand cycles the checks need
  initial
  begin
    #(40 * 50000);
    miscompares++;
    end_sim();
  end
endmodule
